/* hdl/uart_core.sv */
// Serial port core: baud divider, receive and transmit FIFOs, interrupt identification
`timescale 1ns/100ps
`default_nettype none
module uart_core #(
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ref_clk_i,
  output logic baud16_o,
  output logic [7:0] line_format_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_err_i,
  input wire logic rx_frame_err_i,
  input wire logic rx_break_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic tx_shift_empty_i,
  output logic irq_o
);
  import uart_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);

  logic [7:0] irq_enable_reg, fifo_setup_reg, line_format_reg, scratch;
  logic [7:0] baud_divisor_low, baud_divisor_high;
  logic [15:0] divisor, div_period, div_cnt;
  logic [3:0] pre_cnt;
  logic brg_in, brg_tick, baud16, baud16_q, tick16;
  logic acc, wr, rd, divisor_access_bit, wr_div, wr_thr, rd_rbr, rd_iir, rd_lsr, wr_fcr, fcr_toggle;
  logic [3:0] iir_code;
  logic [7:0] rx_mem_d [DEPTH];
  logic [2:0] rx_mem_e [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [PW-1:0] rx_rd, rx_wr, tx_rd, tx_wr;
  logic [PW:0] rx_count, tx_count, rx_limit;
  logic [DEPTH-1:0] err_vec;
  logic rx_push, rx_pop, tx_push, tx_pop, overrun, rx_clr, tx_clr;
  logic [4:0] trig_level;
  logic [3:0] char_bits;
  logic [10:0] timeout_limit, tx_holding_empty_limit, to_cnt, tx_holding_empty_cnt;
  logic timeout_flag, tx_holding_empty_ind, tx_holding_empty_irq, seen_two, ls_pend, rda_pend;

  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_sel_i[0];
  assign wr = acc & wb_we_i;
  assign rd = acc & ~wb_we_i;
  assign divisor_access_bit = line_format_reg[LCR_DIVISOR_ACCESS_BIT];
  assign wr_div = wr & divisor_access_bit & (wb_adr_i[4:2] == REG_DATA || wb_adr_i[4:2] == REG_IER);
  assign wr_thr = wr & ~divisor_access_bit & (wb_adr_i[4:2] == REG_DATA);
  assign rd_rbr = rd & ~divisor_access_bit & (wb_adr_i[4:2] == REG_DATA);
  assign rd_iir = rd & (wb_adr_i[4:2] == REG_IIR_FCR);
  assign rd_lsr = rd & (wb_adr_i[4:2] == REG_LSR);
  assign wr_fcr = wr & (wb_adr_i[4:2] == REG_IIR_FCR);
  assign fcr_toggle = wr_fcr & (wb_dat_i[FCR_EN] != fifo_setup_reg[FCR_EN]);
  assign line_format_o = line_format_reg;
  assign divisor = {baud_divisor_high, baud_divisor_low};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable_reg <= IER_RESET;
      fifo_setup_reg <= FCR_RESET;
      line_format_reg <= LCR_RESET;
      scratch <= 8'h00;
      baud_divisor_low <= DIVISOR_RESET[7:0];
      baud_divisor_high <= DIVISOR_RESET[15:8];
    end else if (wr) begin
      case (wb_adr_i[4:2])
        REG_DATA: begin
          if (divisor_access_bit) begin
            baud_divisor_low <= wb_dat_i[7:0];
          end
        end
        REG_IER: begin
          if (divisor_access_bit) begin
            baud_divisor_high <= wb_dat_i[7:0];
          end else begin
            irq_enable_reg <= {4'h0, wb_dat_i[3:0]};
          end
        end
        REG_IIR_FCR: fifo_setup_reg <= {wb_dat_i[7:6], 5'h00, wb_dat_i[FCR_EN]};
        REG_LCR: line_format_reg <= wb_dat_i[7:0];
        REG_SCR: scratch <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      case (wb_adr_i[4:2])
        REG_DATA: wb_dat_o <= {24'h00_0000, divisor_access_bit ? baud_divisor_low : rx_mem_d[rx_rd]};
        REG_IER: wb_dat_o <= {24'h00_0000, divisor_access_bit ? baud_divisor_high : irq_enable_reg};
        REG_IIR_FCR: wb_dat_o <= {24'h00_0000, {2{fifo_setup_reg[FCR_EN]}}, 2'b00, iir_code};
        REG_LCR: wb_dat_o <= {24'h00_0000, line_format_reg};
        REG_LSR: wb_dat_o <= {24'h00_0000, |err_vec, tx_holding_empty_ind & tx_shift_empty_i, tx_holding_empty_ind,
                              rx_count != 0 ? rx_mem_e[rx_rd] : 3'b000, overrun, rx_count != 0};
        REG_SCR: wb_dat_o <= {24'h00_0000, scratch};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // reference divided by thirteen; brg_tick pulses once per prescale period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt <= 4'h0;
      brg_in <= 1'b0;
    end else begin
      brg_in <= ref_clk_i;
      if (ref_clk_i & ~brg_in) begin
        pre_cnt <= (pre_cnt == PRESCALE_DIV - 4'h1) ? 4'h0 : pre_cnt + 4'h1;
      end
    end
  end
  assign brg_tick = ref_clk_i & ~brg_in & (pre_cnt == PRESCALE_HIGH_FROM - 4'h1);

  assign div_period = (divisor == 16'h0000) ? 16'h0003 : divisor;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 16'h0000;
    end else if (wr_div) begin
      div_cnt <= 16'h0000;
    end else if (brg_tick) begin
      div_cnt <= (div_cnt >= div_period - 16'h0001) ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud16 <= 1'b0;
      baud16_q <= 1'b0;
    end else begin
      baud16_q <= baud16;
      if (divisor == 16'h0001) begin
        baud16 <= ~(pre_cnt >= PRESCALE_HIGH_FROM);
      end else if (divisor == 16'h0002) begin
        baud16 <= div_cnt[0];
      end else begin
        baud16 <= div_cnt >= 16'h0002;
      end
    end
  end
  assign baud16_o = baud16;
  // one tick per sixteenth of a bit
  assign tick16 = baud16 & ~baud16_q;

  // both stop bits belong to the character time
  assign char_bits = START_BITS + MIN_DATA_BITS + {2'b00, line_format_reg[1:0]}
                   + {3'b000, line_format_reg[LCR_PEN]} + {3'b000, line_format_reg[LCR_STOP]}
                   + 4'h1;
  assign timeout_limit = 11'(int'(char_bits) * TICKS_PER_BIT * TIMEOUT_CHARS);
  assign tx_holding_empty_limit = 11'(int'(char_bits - 4'h1) * TICKS_PER_BIT);

  // Outside FIFO mode the receive side holds a single character
  assign rx_limit = fifo_setup_reg[FCR_EN] ? DEPTH_C : (PW + 1)'(1);
  assign rx_clr = fcr_toggle | (wr_fcr & wb_dat_i[FCR_RX_CLR]);
  assign tx_clr = fcr_toggle | (wr_fcr & wb_dat_i[FCR_TX_CLR]);
  assign rx_push = rx_valid_i & (rx_count != rx_limit);
  assign rx_pop = rd_rbr & (rx_count != 0);

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_clr) begin
      rx_rd <= '0;
      rx_wr <= '0;
      rx_count <= '0;
    end else begin
      if (rx_push) begin
        rx_mem_d[rx_wr] <= rx_data_i;
        rx_mem_e[rx_wr] <= {rx_break_i, rx_frame_err_i, rx_parity_err_i};
        rx_wr <= (rx_wr == PW'(DEPTH - 1)) ? '0 : rx_wr + PW'(1);
      end
      if (rx_pop) begin
        rx_rd <= (rx_rd == PW'(DEPTH - 1)) ? '0 : rx_rd + PW'(1);
      end
      rx_count <= rx_count + (PW + 1)'(rx_push) - (PW + 1)'(rx_pop);
    end
  end

  // Per-entry error flags of occupied slots
  for (genvar i = 0; i < DEPTH; i++) begin : g_err
    logic [PW-1:0] rel;
    assign rel = PW'(i) - rx_rd;
    assign err_vec[i] = ((PW + 1)'(rel) < rx_count) & (|rx_mem_e[i]);
  end

  // Overrun: set wins over the clearing status read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun <= 1'b0;
    end else begin
      overrun <= (rx_valid_i & (rx_count == rx_limit)) | (overrun & ~rd_lsr);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_clr) begin
      to_cnt <= 11'h000;
      timeout_flag <= 1'b0;
    end else if (timeout_flag) begin
      if (rx_pop) begin
        timeout_flag <= 1'b0;
        to_cnt <= 11'h000;
      end
    end else if (rx_push || rx_pop || rx_count == 0) begin
      to_cnt <= 11'h000;
    // four quiet character times with data waiting
    end else if (tick16) begin
      if (to_cnt >= timeout_limit - 11'h001) begin
        timeout_flag <= 1'b1;
      end else begin
        to_cnt <= to_cnt + 11'h001;
      end
    end
  end

  assign tx_push = wr_thr & (tx_count != DEPTH_C);
  assign tx_valid_o = tx_count != 0;
  assign tx_data_o = tx_mem[tx_rd];
  assign tx_pop = tx_valid_o & tx_ready_i;

  always_ff @(posedge clk_i) begin
    if (rst_i || tx_clr) begin
      tx_rd <= '0;
      tx_wr <= '0;
      tx_count <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wr] <= wb_dat_i[7:0];
        tx_wr <= (tx_wr == PW'(DEPTH - 1)) ? '0 : tx_wr + PW'(1);
      end
      if (tx_pop) begin
        tx_rd <= (tx_rd == PW'(DEPTH - 1)) ? '0 : tx_rd + PW'(1);
      end
      tx_count <= tx_count + (PW + 1)'(tx_push) - (PW + 1)'(tx_pop);
    end
  end

  // late empty indication after a lone byte
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_clr) begin
      tx_holding_empty_ind <= 1'b1;
      seen_two <= 1'b0;
      tx_holding_empty_cnt <= 11'h000;
    end else if (tx_push || tx_count != 0) begin
      tx_holding_empty_ind <= 1'b0;
      tx_holding_empty_cnt <= 11'h000;
      seen_two <= seen_two | (tx_count >= (PW + 1)'(2));
    end else if (!tx_holding_empty_ind) begin
      if (seen_two || tx_holding_empty_cnt >= tx_holding_empty_limit) begin
        tx_holding_empty_ind <= 1'b1;
        seen_two <= 1'b0;
      end else if (tick16) begin
        tx_holding_empty_cnt <= tx_holding_empty_cnt + 11'h001;
      end
    end
  end

  // holding empty latch, set wins over clear
  // enable change raises it at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_holding_empty_irq <= 1'b0;
    end else if (fcr_toggle || (!tx_holding_empty_ind && !tx_push && tx_count == 0 &&
                 (seen_two || tx_holding_empty_cnt >= tx_holding_empty_limit))) begin
      tx_holding_empty_irq <= 1'b1;
    end else if (wr_thr || (rd_iir && iir_code == IIR_TX_HOLDING_EMPTY)) begin
      tx_holding_empty_irq <= 1'b0;
    end
  end

  assign ls_pend = irq_enable_reg[IER_RLS] & (overrun | ((rx_count != 0) & (|rx_mem_e[rx_rd])));
  assign rda_pend = irq_enable_reg[IER_RDA] &
                    (fifo_setup_reg[FCR_EN] ? ({{(5 - PW){1'b0}}, rx_count[PW-1:0]} +
                     {4'h0, rx_count[PW]} * 5'(DEPTH) >= trig_level) : (rx_count != 0));

  always_comb begin
    case (fifo_setup_reg[FCR_TRIG +: 2])
      2'b00: trig_level = TRIG_LVL_0;
      2'b01: trig_level = TRIG_LVL_1;
      2'b10: trig_level = TRIG_LVL_2;
      default: trig_level = TRIG_LVL_3;
    endcase
  end

  always_comb begin
    if (ls_pend) begin
      iir_code = IIR_RLS;
    end else if (rda_pend) begin
      iir_code = IIR_RDA;
    end else if (irq_enable_reg[IER_RDA] && fifo_setup_reg[FCR_EN] && timeout_flag) begin
      iir_code = IIR_CTO;
    end else if (irq_enable_reg[IER_TX_HOLDING_EMPTY] && tx_holding_empty_irq) begin
      iir_code = IIR_TX_HOLDING_EMPTY;
    end else begin
      iir_code = IIR_NONE;
    end
  end
  assign irq_o = ~iir_code[0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fifo_flip;
    fcr_toggle;
  endsequence
  sequence s_tx_holding_empty_up;
    tx_holding_empty_irq && tx_holding_empty_ind;
  endsequence

  a_divisor_reload: assert property (wr_div |=> div_cnt == 16'h0000)
    else $error("baud counter not reloaded");
  a_period_wrap: assert property (brg_tick && !wr_div && div_cnt >= div_period - 16'h0001
    |=> div_cnt == 16'h0000)
    else $error("divisor period overrun");
  a_div_one_inverse: assert property (divisor == 16'h0001 && $past(divisor) == 16'h0001
    |-> baud16 == !$past(pre_cnt >= PRESCALE_HIGH_FROM))
    else $error("divisor one not inverse");
  a_low_two_clocks: assert property (divisor >= 16'h0003 && !wr_div && brg_tick
    && div_cnt == divisor - 16'h0001 |=> ##1 !baud16 ##1 !baud16)
    else $error("output not low after wrap");
  a_ls_priority: assert property (ls_pend |-> irq_o && iir_code == IIR_RLS)
    else $error("line status not first");
  a_data_ready: assert property (rx_push && !rx_clr |=> rx_count != 0)
    else $error("data ready not set");
  a_timeout_clear: assert property (timeout_flag && rx_pop && !rx_clr
    |=> !timeout_flag && to_cnt == 11'h000)
    else $error("timeout not cleared by read");
  a_tx_holding_empty_clear: assert property (tx_holding_empty_irq && wr_thr && !fcr_toggle |=> !tx_holding_empty_irq)
    else $error("holding empty not cleared");
  a_fifo_flip_tx_holding_empty: assert property (s_fifo_flip |=> s_tx_holding_empty_up)
    else $error("no immediate transmit interrupt");
  a_polled_quiet: assert property (!irq_enable_reg[IER_RDA]
    |-> iir_code != IIR_RDA && iir_code != IIR_CTO)
    else $error("receive indication in polled mode");
endmodule
`default_nettype wire

/* hdl/uart_pkg.sv */
// Register map, field layout, reset values and counts for the serial port core
package uart_pkg;
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_IER = 3'h1;
  localparam logic [2:0] REG_IIR_FCR = 3'h2;
  localparam logic [2:0] REG_LCR = 3'h3;
  localparam logic [2:0] REG_LSR = 3'h5;
  localparam logic [2:0] REG_SCR = 3'h7;
  localparam int ADDR_LSB = 2;
  localparam int IER_RDA = 0;
  localparam int IER_TX_HOLDING_EMPTY = 1;
  localparam int IER_RLS = 2;
  localparam int FCR_EN = 0;
  localparam int FCR_RX_CLR = 1;
  localparam int FCR_TX_CLR = 2;
  localparam int FCR_TRIG = 6;
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_DIVISOR_ACCESS_BIT = 7;
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_RLS = 4'h6;
  localparam logic [3:0] IIR_RDA = 4'h4;
  localparam logic [3:0] IIR_CTO = 4'hC;
  localparam logic [3:0] IIR_TX_HOLDING_EMPTY = 4'h2;
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  localparam logic [3:0] PRESCALE_DIV = 4'hD;
  localparam logic [3:0] PRESCALE_HIGH_FROM = 4'h7;
  localparam int TICKS_PER_BIT = 16;
  localparam int TIMEOUT_CHARS = 4;
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;
  localparam logic [3:0] START_BITS = 4'h1;
  localparam logic [4:0] TRIG_LVL_0 = 5'h01;
  localparam logic [4:0] TRIG_LVL_1 = 5'h04;
  localparam logic [4:0] TRIG_LVL_2 = 5'h08;
  localparam logic [4:0] TRIG_LVL_3 = 5'h0E;
endpackage

/* verif/serial_peer_model.sv */
// Far-side stand-in: receive shifter pulses and a transmit shifter with stall
`timescale 1ns/100ps
`default_nettype none
module serial_peer_model #(
  parameter int SHIFT_CYCLES = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [7:0] push_data_i,
  input wire logic push_perr_i,
  input wire logic stall_i,
  input wire logic tx_valid_i,
  output logic rx_valid_o = 1'b0,
  output logic [7:0] rx_data_o = 8'h00,
  output logic rx_perr_o = 1'b0,
  output logic tx_ready_o,
  output logic tx_empty_o
);
  int busy = 0;
  // Idle data lines toggle so a stale byte never passes for a fresh one
  always @(posedge clk_i) begin
    rx_valid_o <= push_i && !rst_i;
    rx_data_o <= push_i ? push_data_i : ~rx_data_o;
    rx_perr_o <= push_i ? push_perr_i : ~rx_perr_o;
  end
  // A taken byte keeps the shifter busy, so the core sees a slow consumer
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 0;
    end else if (tx_valid_i && tx_ready_o) begin
      busy <= SHIFT_CYCLES;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end
  end
  assign tx_ready_o = !stall_i && busy == 0;
  assign tx_empty_o = busy == 0;
endmodule
`default_nettype wire

/* verif/uart_baud_fifo_interrupts_tb_top.sv */
// Self-checking bench: register reads, baud timing, receive and transmit interrupts
`timescale 1ns/100ps
`default_nettype none
module uart_baud_fifo_interrupts_tb_top;
  import uart_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic ref_clk = 1'b0;
  logic push = 1'b0;
  logic perr = 1'b0;
  logic stall = 1'b1;
  logic [7:0] pdata = 8'h00;
  logic [31:0] rdat;
  logic [31:0] seed = 32'h0000_000D;
  logic [7:0] rx_data, tx_data, lfmt;
  logic ack, baud16, rx_valid, rx_perr, tx_valid, tx_ready, tx_empty, irq;
  logic [7:0] exp_q[$], msk_q[$], txq[$], rxq[$];
  int error_cnt = 0;
  int checked = 0;
  int acc = 0;
  int lo, hi, n, t;
  logic [15:0] dv [5] = '{16'h0000, 16'h0002, 16'h0003, 16'h0005, 16'h0001};
  always #4 clk_i = ~clk_i;
  // 24 MHz reference stepped on the core clock; each edge jitters by one cycle
  always @(posedge clk_i) begin
    if (acc >= 77) begin
      acc <= acc - 77;
      ref_clk <= ~ref_clk;
    end else begin
      acc <= acc + 48;
    end
  end
  uart_core #(.DEPTH(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ref_clk_i(ref_clk), .baud16_o(baud16), .line_format_o(lfmt),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_parity_err_i(rx_perr),
    .rx_frame_err_i(1'b0), .rx_break_i(1'b0), .tx_data_o(tx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_shift_empty_i(tx_empty), .irq_o(irq));
  serial_peer_model peer (
    .clk_i(clk_i), .rst_i(rst_i), .push_i(push), .push_data_i(pdata),
    .push_perr_i(perr), .stall_i(stall), .tx_valid_i(tx_valid), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_perr_o(rx_perr), .tx_ready_o(tx_ready), .tx_empty_o(tx_empty));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g, input int tol);
    logic ok;
    ok = (tol == 0) ? (g === e) : (g + tol >= e && g <= e + tol);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic hang(input string what);
    error_cnt++;
    $display("[ERR] %s expected done seen timeout", what);
    close_out();
  endtask
  // Classic single cycle; reads leave their expectation for the monitor
  task automatic bus(input logic [2:0] idx, input logic w, input logic [7:0] d,
      input logic [7:0] e = 8'h00, input logic [7:0] m = 8'h00);
    int k;
    k = 0;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    adr <= {idx, 2'b00};
    we <= w;
    wdat <= {24'h00_0000, d};
    sel <= 4'h1;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) hang("bus ack");
    @(posedge clk_i);
  endtask
  task automatic rxb(input logic [7:0] d, input logic pe);
    push <= 1'b1;
    pdata <= d;
    perr <= pe;
    @(posedge clk_i);
    push <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // Selector: 0 interrupt, 1 transmit valid, 2 shifter empty, 3 baud output
  task automatic wt(input int s, input logic v, input int lim, output int c);
    c = 0;
    while ((s == 0 ? irq : s == 1 ? tx_valid : s == 2 ? tx_empty : baud16) !== v
        && c < lim) begin
      @(posedge clk_i);
      c++;
    end
    if (c >= lim) hang("level wait");
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      chk("read data", exp_q.size() > 0 ? {24'h0, exp_q.pop_front()} : 32'hFFFF_FFFF,
        rdat & {24'h0, msk_q.size() > 0 ? msk_q.pop_front() : 8'hFF}, 0);
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      chk("tx byte", txq.size() > 0 ? {24'h0, txq.pop_front()} : 32'hFFFF_FFFF,
        {24'h0, tx_data}, 0);
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(REG_IER, 0, 0, IER_RESET, 8'hFF);
    bus(REG_IIR_FCR, 0, 0, {4'h0, IIR_NONE}, 8'hFF);
    bus(REG_LCR, 0, 0, LCR_RESET, 8'hFF);
    bus(REG_LSR, 0, 0, 8'h60, 8'hFF);
    bus(3'h6, 1, 8'hA5);
    bus(3'h6, 0, 0, 8'h00, 8'hFF);
    bus(REG_SCR, 1, 8'h5A);
    bus(REG_SCR, 0, 0, 8'h5A, 8'hFF);
    bus(REG_LCR, 1, 8'h80);
    chk("line format", 32'h80, {24'h0, lfmt}, 0);
    bus(REG_DATA, 0, 0, DIVISOR_RESET[7:0], 8'hFF);
    foreach (dv[i]) begin
      bus(REG_DATA, 1, dv[i][7:0]);
      bus(REG_IER, 1, dv[i][15:8]);
      bus(REG_DATA, 0, 0, dv[i][7:0], 8'hFF);
      wt(3, 1, 3000, n);
      wt(3, 0, 3000, n);
      wt(3, 1, 3000, lo);
      wt(3, 0, 3000, hi);
      t = (dv[i] == 0) ? 3 : dv[i];
      chk("baud period", t * 677 / 10, lo + hi, 3);
      if (dv[i] >= 3) chk("baud low", 135, lo, 3);
      if (dv[i] == 2) chk("baud low", 68, lo, 3);
    end
    bus(REG_LCR, 1, 8'h04);
    bus(REG_IIR_FCR, 1, 8'h47);
    bus(REG_IER, 1, 8'h01);
    bus(REG_IIR_FCR, 0, 0, 8'hC1, 8'hCF);
    for (int i = 0; i < 4; i++) begin
      chk("irq", 0, irq, 0);
      seed = xs(seed);
      rxq.push_back(seed[7:0]);
      rxb(seed[7:0], 1'b0);
      bus(REG_LSR, 0, 0, 8'h01, 8'h01);
    end
    chk("irq", 1, irq, 0);
    bus(REG_IIR_FCR, 0, 0, 8'hC4, 8'hCF);
    bus(REG_DATA, 0, 0, rxq.pop_front(), 8'hFF);
    chk("irq", 0, irq, 0);
    wt(0, 1, 40000, t);
    chk("timeout cycles", 34662, t, 150);
    bus(REG_IIR_FCR, 0, 0, 8'hCC, 8'hCF);
    bus(REG_DATA, 0, 0, rxq.pop_front(), 8'hFF);
    chk("irq", 0, irq, 0);
    repeat (2) bus(REG_DATA, 0, 0, rxq.pop_front(), 8'hFF);
    bus(REG_LSR, 0, 0, 8'h00, 8'h01);
    bus(REG_IER, 1, 8'h05);
    // Errored byte sits at the head; the fifth one meets a full FIFO and overruns
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      rxb(seed[7:0], i == 0);
    end
    bus(REG_IIR_FCR, 0, 0, 8'hC6, 8'hCF);
    bus(REG_LSR, 0, 0, 8'h83, 8'h83);
    bus(REG_IIR_FCR, 1, 8'h43);
    bus(REG_LSR, 0, 0, 8'h00, 8'h81);
    bus(REG_IER, 1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      rxq.push_back(seed[7:0]);
      rxb(seed[7:0], 1'b0);
    end
    chk("irq", 0, irq, 0);
    bus(REG_IIR_FCR, 0, 0, 8'hC1, 8'hCF);
    repeat (4) bus(REG_DATA, 0, 0, rxq.pop_front(), 8'hFF);
    bus(REG_IER, 1, 8'h02);
    bus(REG_IIR_FCR, 0, 0, 8'hC2, 8'hCF);
    chk("irq", 0, irq, 0);
    bus(REG_IIR_FCR, 1, 8'h00);
    bus(REG_IIR_FCR, 0, 0, 8'h02, 8'hCF);
    bus(REG_IIR_FCR, 1, 8'h41);
    chk("irq", 1, irq, 0);
    bus(REG_IIR_FCR, 0, 0, 8'hC2, 8'hCF);
    bus(REG_IIR_FCR, 0, 0, 8'hC1, 8'hCF);
    stall <= 1'b0;
    txq.push_back(8'h3C);
    bus(REG_DATA, 1, 8'h3C);
    wt(1, 0, 200, t);
    wt(0, 1, 10000, t);
    chk("late empty cycles", 7582, t, 150);
    bus(REG_IIR_FCR, 0, 0, 8'hC2, 8'hCF);
    stall <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      txq.push_back(seed[7:0]);
      bus(REG_DATA, 1, seed[7:0]);
    end
    chk("irq", 0, irq, 0);
    bus(REG_LSR, 0, 0, 8'h00, 8'h60);
    stall <= 1'b0;
    wt(1, 0, 2000, t);
    repeat (2) @(posedge clk_i);
    chk("irq", 1, irq, 0);
    seed = xs(seed);
    txq.push_back(seed[7:0]);
    bus(REG_DATA, 1, seed[7:0]);
    chk("irq", 0, irq, 0);
    wt(0, 1, 10000, t);
    chk("late empty cycles", 7582, t, 150);
    wt(2, 1, 200, t);
    bus(REG_LSR, 0, 0, 8'h60, 8'h60);
    chk("tx left", 0, txq.size(), 0);
    close_out();
  end
endmodule
`default_nettype wire
